// *** tdc_regs.svh ***
// Timing counts and sizes for the theft deterrent controller
`ifndef TDC_REGS_SVH
`define TDC_REGS_SVH
// System clock period and one second, both in ns
`define TDC_CLK_PERIOD_NS 10
`define TDC_SECOND_NS 1000000000
// Clock cycles in one second, derived from the two figures above
`define TDC_TICK_CYCLES (`TDC_SECOND_NS / `TDC_CLK_PERIOD_NS)
// Warning length, relock wait and remote_alarm_request length in seconds
`define TDC_WARN_S 5'h1b
`define TDC_RELOCK_S 5'h1e
`define TDC_REMOTE_ALARM_REQUEST_S 5'h1b
// Lock output hold in seconds
`define TDC_LOCK_S 5'h01
// Steps of the confirm chirp: horn once, flasher twice
`define TDC_CHIRP_STEPS 3'h4
// Width of the second timers
`define TDC_SEC_W 5
// Number of door/hood/tailgate switches and of lock switches
`define TDC_NUM_DOORS 6
`define TDC_NUM_LOCKS 5
`endif

// *** tdc_pkg.sv ***
// Types shared by the theft deterrent controller files
`include "tdc_regs.svh"
package tdc_pkg;
  // Anti-theft mode
  typedef enum logic [2:0] {
    TDC_NORMAL,
    TDC_ARM_READY,
    TDC_ARMED,
    TDC_WARN,
    TDC_WARN_DONE,
    TDC_RELOCK_WAIT
  } tdc_state_t;

  // Vehicle switch levels, high = open / locked / present
  typedef struct packed {
    logic [`TDC_NUM_DOORS-1:0] door_open;
    logic [`TDC_NUM_LOCKS-1:0] lock_sw;
    logic key_in;
    logic ign_on;
    logic engine_run;
    logic restore_armed;
  } tdc_pins_t;

  // Remote key receiver lines, high while a button code is received
  typedef struct packed {
    logic lock;
    logic unlock;
    logic remote_alarm_request;
    logic light_request_a;
  } tdc_remote_t;
endpackage : tdc_pkg

// *** tdc_sync.sv ***
// Two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/100ps
module tdc_sync #(
  parameter int W = 1
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_q; // First stage, read only by the second
  logic [W-1:0] sync_d;

  // Next value of the second stage
  always_comb
  begin
    sync_d = meta_q;
  end

  // Both stages clear to zero under reset
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      meta_q <= '0;
      o_q <= '0;
    end
    else
    begin
      meta_q <= i_d;
      o_q <= sync_d;
    end
  end
endmodule : tdc_sync

// *** tdc_tick.sv ***
// One-second enable pulse divided down from the system clock
`timescale 1ns/100ps
`include "tdc_regs.svh"
module tdc_tick #(
  parameter int TICK_CYCLES = `TDC_TICK_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  output logic o_tick
);
  localparam int CW = $clog2(TICK_CYCLES + 1);
  logic [CW-1:0] cnt_q; // Cycles within the current second
  logic [CW-1:0] cnt_d;
  logic tick_d;

  // Wrap at the end of each second and flag it
  always_comb
  begin
    tick_d = (cnt_q == CW'(TICK_CYCLES - 1));
    cnt_d = tick_d ? '0 : cnt_q + 1'b1;
  end

  // Counter and pulse registers
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cnt_q <= '0;
      o_tick <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      o_tick <= tick_d;
    end
  end
endmodule : tdc_tick

// *** tdc_ctrl.sv ***
// Theft deterrent and remote_alarm_request alarm controller, top level
`timescale 1ns/100ps
`include "tdc_regs.svh"
// Operation
// - Any door switch open means doors open
// - Any lock switch locked means doors locked
// - Remote lock, no key, closed: arm, chirp
// - Remote lock while armed repeats the chirp
// - Remote lock, door open: lock, armed-ready
// - Armed-ready: key or unlock returns normal
// - Armed-ready: door closes, chirp and armed
// - Unlock then 30 s idle: relock and arm
// - Else only a non-unlock remote command in warning enters armed
// - Remote unlock or engine start leaves armed
// - Door open or forced unlock starts warning
// - Warning blinks horn, flasher 1 s, 27 s
// - Any remote command ends a warning
// - Ignition on cancels warning at once
// - Cancelled warning turns horn, flasher off
// - Restored armed state starts a warning
// - Remote_alarm_request request sounds horn 27 s
// - Any remote command stops remote_alarm_request
// - Remote_alarm_request request cancels a theft warning
// - Theft warning start stops remote_alarm_request
// - Remote_alarm_request allowed in listed states, mode kept
module tdc_ctrl #(
  parameter int TICK_CYCLES = `TDC_TICK_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire tdc_pkg::tdc_pins_t i_pins,
  input wire tdc_pkg::tdc_remote_t i_remote,
  output logic o_lock,
  output logic o_horn,
  output logic o_hazard,
  output logic o_remote_alarm_request,
  output tdc_pkg::tdc_state_t o_state
);
  localparam int PW = $bits(tdc_pkg::tdc_pins_t);
  localparam int RW = $bits(tdc_pkg::tdc_remote_t);

  tdc_pkg::tdc_pins_t pins_s; // Synchronised switch levels
  tdc_pkg::tdc_remote_t rk_s; // Synchronised remote lines
  tdc_pkg::tdc_remote_t rk_prev_q; // Remote lines one cycle ago
  tdc_pkg::tdc_remote_t rk_evt; // Remote button press events
  logic tick; // One-second enable
  logic door_open; // Any door open
  logic door_prev_q;
  logic locked; // Any lock switch locked
  logic locked_prev_q;
  logic rk_any;
  logic live; // Start-up settled
  logic warn_start;

  tdc_pkg::tdc_state_t state_q, state_d; // Anti-theft mode
  logic [`TDC_SEC_W-1:0] st_sec_q, st_sec_d; // Warning / relock seconds
  logic [`TDC_SEC_W-1:0] pan_sec_q, pan_sec_d; // Remote_alarm_request seconds
  logic [`TDC_SEC_W-1:0] lock_sec_q, lock_sec_d; // Lock output hold
  logic [2:0] chirp_q, chirp_d; // Confirm chirp steps left
  logic [1:0] boot_q, boot_d; // Start-up countdown
  logic remote_alarm_request_q, remote_alarm_request_d;
  logic phase_q, phase_d; // Warning blink phase
  logic horn_d, hazard_d;

  // Pin synchronisers
  tdc_sync #(.W(PW)) u_pin_sync (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_d(i_pins),
    .o_q(pins_s)
  );
  tdc_sync #(.W(RW)) u_rk_sync (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_d(i_remote),
    .o_q(rk_s)
  );

  // Shared second timebase
  tdc_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .o_tick(tick)
  );

  // Start a chirp of horn once and flasher twice
  function automatic logic [2:0] chirp_start();
    chirp_start = `TDC_CHIRP_STEPS;
  endfunction : chirp_start

  // Door and lock summaries and remote press edges
  always_comb
  begin
    door_open = |pins_s.door_open;
    locked = |pins_s.lock_sw;
    live = (boot_q == 2'h0);
    rk_evt = live ? (rk_s & ~rk_prev_q) : '0;
    rk_any = |rk_evt;
  end

  // Mode, timers and remote_alarm_request next values
  always_comb
  begin
    state_d = state_q;
    st_sec_d = st_sec_q;
    pan_sec_d = pan_sec_q;
    lock_sec_d = lock_sec_q;
    chirp_d = chirp_q;
    remote_alarm_request_d = remote_alarm_request_q;
    phase_d = phase_q;
    boot_d = boot_q;
    // Time-driven countdowns
    if (tick)
    begin
      if (chirp_q != 3'h0)
        chirp_d = chirp_q - 3'h1;
      if (lock_sec_q != '0)
        lock_sec_d = lock_sec_q - 1'b1;
      if (st_sec_q != '0)
        st_sec_d = st_sec_q - 1'b1;
      if (pan_sec_q != '0)
        pan_sec_d = pan_sec_q - 1'b1;
      phase_d = ~phase_q;
    end
    if (!live)
    begin
      // Wait for the synchronisers, then check the stored mode
      boot_d = boot_q - 2'h1;
      if (boot_q == 2'h1 && pins_s.restore_armed)
      begin
        state_d = tdc_pkg::TDC_WARN;
        st_sec_d = `TDC_WARN_S;
        phase_d = 1'b1;
      end
    end
    else
    begin
      case (state_q)
        tdc_pkg::TDC_NORMAL, tdc_pkg::TDC_RELOCK_WAIT:
        begin
          if (rk_evt.lock && !pins_s.key_in)
          begin
            lock_sec_d = `TDC_LOCK_S;
            if (door_open)
              state_d = tdc_pkg::TDC_ARM_READY;
            else
            begin
              state_d = tdc_pkg::TDC_ARMED;
              chirp_d = chirp_start();
            end
          end
          else if (rk_evt.unlock)
          begin
            state_d = tdc_pkg::TDC_RELOCK_WAIT;
            st_sec_d = `TDC_RELOCK_S;
          end
          else if (state_q == tdc_pkg::TDC_RELOCK_WAIT)
          begin
            if (door_open || pins_s.key_in)
            begin
              state_d = tdc_pkg::TDC_NORMAL;
              st_sec_d = '0;
            end
            else if (tick && st_sec_q == `TDC_SEC_W'(1))
            begin
              state_d = tdc_pkg::TDC_ARMED;
              lock_sec_d = `TDC_LOCK_S;
              chirp_d = chirp_start();
            end
          end
        end
        tdc_pkg::TDC_ARM_READY:
        begin
          // Of the lock switches, only a locked-to-unlocked change drops arming, since the lock
          // actuator may not have moved the switches yet on entry
          if (pins_s.key_in || (locked_prev_q && !locked) || rk_evt.unlock)
            state_d = tdc_pkg::TDC_NORMAL;
          else if (!door_open)
          begin
            state_d = tdc_pkg::TDC_ARMED;
            chirp_d = chirp_start();
          end
        end
        tdc_pkg::TDC_ARMED:
        begin
          if (rk_evt.unlock)
          begin
            state_d = tdc_pkg::TDC_RELOCK_WAIT;
            st_sec_d = `TDC_RELOCK_S;
          end
          else if (pins_s.engine_run)
            state_d = tdc_pkg::TDC_NORMAL;
          // Opening edge only: a door left open after a cancelled warning
          // must not restart the warning at once
          else if ((door_open && !door_prev_q) || (locked_prev_q && !locked))
          begin
            state_d = tdc_pkg::TDC_WARN;
            st_sec_d = `TDC_WARN_S;
            phase_d = 1'b1;
          end
          else if (rk_evt.lock)
            chirp_d = chirp_start();
        end
        tdc_pkg::TDC_WARN:
        begin
          if (pins_s.ign_on)
          begin
            state_d = tdc_pkg::TDC_NORMAL;
            st_sec_d = '0;
          end
          else if (rk_evt.unlock)
          begin
            state_d = tdc_pkg::TDC_RELOCK_WAIT;
            st_sec_d = `TDC_RELOCK_S;
          end
          else if (rk_any)
          begin
            state_d = tdc_pkg::TDC_ARMED;
            st_sec_d = '0;
          end
          else if (tick && st_sec_q == `TDC_SEC_W'(1))
            state_d = tdc_pkg::TDC_WARN_DONE;
        end
        tdc_pkg::TDC_WARN_DONE:
        begin
          if (rk_evt.unlock)
          begin
            state_d = tdc_pkg::TDC_RELOCK_WAIT;
            st_sec_d = `TDC_RELOCK_S;
          end
          else if (pins_s.engine_run)
            state_d = tdc_pkg::TDC_NORMAL;
          else if (door_open && !door_prev_q)
          begin
            state_d = tdc_pkg::TDC_WARN;
            st_sec_d = `TDC_WARN_S;
            phase_d = 1'b1;
          end
        end
        default:
          state_d = tdc_pkg::TDC_NORMAL;
      endcase
    end
    // Remote_alarm_request alarm runs beside the anti-theft mode
    warn_start = (state_d == tdc_pkg::TDC_WARN) && (state_q != tdc_pkg::TDC_WARN);
    if (warn_start)
      chirp_d = 3'h0;
    if (remote_alarm_request_q)
    begin
      if (rk_any || warn_start)
      begin
        remote_alarm_request_d = 1'b0;
        pan_sec_d = '0;
      end
      else if (tick && pan_sec_q == `TDC_SEC_W'(1))
        remote_alarm_request_d = 1'b0;
    end
    else if (rk_evt.remote_alarm_request && !warn_start
             && (state_q == tdc_pkg::TDC_ARM_READY || state_q == tdc_pkg::TDC_ARMED
                 || state_q == tdc_pkg::TDC_WARN_DONE
                 || state_q == tdc_pkg::TDC_RELOCK_WAIT))
    begin
      remote_alarm_request_d = 1'b1;
      pan_sec_d = `TDC_REMOTE_ALARM_REQUEST_S;
    end
    // Output drive: leaving the warning drops its blink at once
    horn_d = (chirp_d == `TDC_CHIRP_STEPS) || remote_alarm_request_d
             || ((state_d == tdc_pkg::TDC_WARN) && phase_d);
    hazard_d = (chirp_d != 3'h0 && !chirp_d[0])
               || ((state_d == tdc_pkg::TDC_WARN) && phase_d);
  end

  // Registers of the controller and its outputs
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_q <= tdc_pkg::TDC_NORMAL;
      st_sec_q <= '0;
      pan_sec_q <= '0;
      lock_sec_q <= '0;
      chirp_q <= 3'h0;
      remote_alarm_request_q <= 1'b0;
      phase_q <= 1'b0;
      boot_q <= 2'h3;
      rk_prev_q <= '0;
      door_prev_q <= 1'b0;
      locked_prev_q <= 1'b0;
      o_lock <= 1'b0;
      o_horn <= 1'b0;
      o_hazard <= 1'b0;
      o_remote_alarm_request <= 1'b0;
      o_state <= tdc_pkg::TDC_NORMAL;
    end
    else
    begin
      state_q <= state_d;
      st_sec_q <= st_sec_d;
      pan_sec_q <= pan_sec_d;
      lock_sec_q <= lock_sec_d;
      chirp_q <= chirp_d;
      remote_alarm_request_q <= remote_alarm_request_d;
      phase_q <= phase_d;
      boot_q <= boot_d;
      rk_prev_q <= rk_s;
      door_prev_q <= door_open;
      locked_prev_q <= locked;
      o_lock <= (lock_sec_d != '0);
      o_horn <= horn_d;
      o_hazard <= hazard_d;
      o_remote_alarm_request <= remote_alarm_request_d;
      o_state <= state_d;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  arm_closed_a: assert property (live && state_q == tdc_pkg::TDC_NORMAL && rk_evt.lock
    && !pins_s.key_in && !door_open |=> state_q == tdc_pkg::TDC_ARMED
    && chirp_q == `TDC_CHIRP_STEPS && o_lock)
    else $error("remote lock with doors closed did not arm");
  ready_open_a: assert property (live && state_q == tdc_pkg::TDC_NORMAL && rk_evt.lock
    && !pins_s.key_in && door_open |=> state_q == tdc_pkg::TDC_ARM_READY
    && chirp_q == 3'h0 && o_lock)
    else $error("remote lock with door open did not enter armed-ready");
  ready_drop_a: assert property (live && state_q == tdc_pkg::TDC_ARM_READY
    && pins_s.key_in |=> state_q == tdc_pkg::TDC_NORMAL)
    else $error("key in armed-ready did not return to normal");
  arm_entry_a: assert property (state_q != tdc_pkg::TDC_ARMED
    && state_d == tdc_pkg::TDC_ARMED && state_q != tdc_pkg::TDC_WARN
    |-> chirp_d == `TDC_CHIRP_STEPS)
    else $error("armed entered without confirm chirp");
  warn_start_a: assert property (live && state_q == tdc_pkg::TDC_ARMED && door_open
    && !door_prev_q && !rk_evt.unlock && !pins_s.engine_run
    |=> state_q == tdc_pkg::TDC_WARN && st_sec_q == `TDC_WARN_S)
    else $error("door open while armed did not start a 27 s warning");
  remote_end_a: assert property (live && state_q == tdc_pkg::TDC_WARN && rk_any
    |=> state_q != tdc_pkg::TDC_WARN ##1 !o_hazard)
    else $error("remote command did not end the warning");
  ign_cancel_a: assert property (live && state_q == tdc_pkg::TDC_WARN && pins_s.ign_on
    |=> state_q == tdc_pkg::TDC_NORMAL ##1 !o_hazard)
    else $error("ignition on did not cancel the warning");
  remote_alarm_request_stop_a: assert property (remote_alarm_request_q && rk_any |=> !remote_alarm_request_q ##1 !o_remote_alarm_request)
    else $error("remote command did not stop the remote_alarm_request alarm");
  remote_alarm_request_warn_a: assert property (remote_alarm_request_q && warn_start
    |=> !remote_alarm_request_q && state_q == tdc_pkg::TDC_WARN)
    else $error("theft warning did not replace the remote_alarm_request alarm");
  remote_alarm_request_keep_a: assert property (!remote_alarm_request_q && remote_alarm_request_d |=> remote_alarm_request_q && pan_sec_q == `TDC_REMOTE_ALARM_REQUEST_S
    && state_q == $past(state_d))
    else $error("remote_alarm_request start disturbed the mode or its length");
endmodule : tdc_ctrl

// *** tdc_car_model.sv ***
// Door, lock, ignition and remote key receiver model
`timescale 1ns/100ps
module tdc_car_model (
  input wire logic i_ref_clk,
  output tdc_pkg::tdc_pins_t o_pins,
  output tdc_pkg::tdc_remote_t o_remote
);
  // All switches closed, unlocked, key out at power up
  initial o_pins = '0;
  // No button code on the air
  initial o_remote = '0;

  // Move the switches just after a falling edge
  task automatic set_pins(input tdc_pkg::tdc_pins_t p);
    @(negedge i_ref_clk);
    o_pins = p;
  endtask : set_pins

  // One button code: high 3 cycles, then quiet 3 cycles
  task automatic press(input tdc_pkg::tdc_remote_t c);
    @(negedge i_ref_clk);
    o_remote = c;
    repeat (3) @(negedge i_ref_clk);
    o_remote = '0;
    repeat (3) @(negedge i_ref_clk);
  endtask : press
endmodule : tdc_car_model

// *** theft_deterrent_controller_test.sv ***
// Self-checking testbench for the theft deterrent controller
`timescale 1ns/100ps
module theft_deterrent_controller_test;
  // Cycles in one shortened second
  localparam int TK = 20;
  // Button codes: lock, unlock, alarm request, light request
  localparam tdc_pkg::tdc_remote_t LK = 4'h8;
  localparam tdc_pkg::tdc_remote_t UL = 4'h4;
  localparam tdc_pkg::tdc_remote_t PA = 4'h2;
  localparam tdc_pkg::tdc_remote_t LI = 4'h1;
  logic i_ref_clk = 1'b0;
  logic i_rstn = 1'b0;
  tdc_pkg::tdc_pins_t pins;
  tdc_pkg::tdc_remote_t remote;
  logic o_lock;
  logic o_horn;
  logic o_hazard;
  logic o_remote_alarm_request;
  tdc_pkg::tdc_state_t o_state;
  // Switch levels the bench asks the model for
  tdc_pkg::tdc_pins_t p;
  int errors = 0;
  int checks_done = 0;
  // Rising edges seen on horn, flasher and lock
  int horn_n = 0;
  int haz_n = 0;
  int lk_n = 0;

  tdc_ctrl #(.TICK_CYCLES(TK)) dut (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_pins(pins),
    .i_remote(remote),
    .o_lock(o_lock),
    .o_horn(o_horn),
    .o_hazard(o_hazard),
    .o_remote_alarm_request(o_remote_alarm_request),
    .o_state(o_state)
  );

  tdc_car_model car (
    .i_ref_clk(i_ref_clk),
    .o_pins(pins),
    .o_remote(remote)
  );

  // 100 MHz clock
  always #5 i_ref_clk = ~i_ref_clk;

  // Count pulses so chirps and blinks can be judged afterwards
  always @(posedge i_ref_clk)
  begin
    if ($rose(o_horn))
      horn_n <= horn_n + 1;
    if ($rose(o_hazard))
      haz_n <= haz_n + 1;
    if ($rose(o_lock))
      lk_n <= lk_n + 1;
  end

  // Print the verdict and stop
  task automatic conclude();
    if (errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  // Compare one value
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Wait up to n cycles for a mode; a hang ends the run
  task automatic wait_st(input tdc_pkg::tdc_state_t s, input int n);
    for (int i = 0; i < n && o_state !== s; i++)
      @(negedge i_ref_clk);
    chk(8'(o_state), 8'(s));
    if (o_state !== s)
      conclude();
  endtask : wait_st

  // Let n seconds pass
  task automatic sec(input int n);
    repeat (n * TK) @(negedge i_ref_clk);
  endtask : sec

  // Clear the pulse counters
  task automatic clr();
    horn_n = 0;
    haz_n = 0;
    lk_n = 0;
  endtask : clr

  // Compare horn and flasher pulse counts
  task automatic cnt(input logic [7:0] h, input logic [7:0] z);
    chk(8'(horn_n), h);
    chk(8'(haz_n), z);
  endtask : cnt

  // Reset with the stored-mode strap given
  task automatic rst(input logic restore);
    p = '0;
    p.restore_armed = restore;
    car.set_pins(p);
    i_rstn = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    i_rstn = 1'b1;
    repeat (6) @(negedge i_ref_clk);
  endtask : rst

  // Change one switch group through the model
  task automatic put();
    car.set_pins(p);
  endtask : put

  // Arm from reset and let the chirp finish
  task automatic arm();
    rst(1'b0);
    clr();
    car.press(LK);
    wait_st(tdc_pkg::TDC_ARMED, 10);
    sec(5);
  endtask : arm

  // Remote lock arms with one horn and two flasher pulses, again when armed
  task automatic s_arm();
    arm();
    cnt(8'h1, 8'h2);
    chk(8'(lk_n), 8'h1);
    clr();
    car.press(LK);
    sec(5);
    cnt(8'h1, 8'h2);
    wait_st(tdc_pkg::TDC_ARMED, 1);
  endtask : s_arm

  // Lock with a door open, then close it; key cancels armed-ready
  task automatic s_ready();
    rst(1'b0);
    p.door_open[0] = 1'b1;
    put();
    clr();
    car.press(LK);
    wait_st(tdc_pkg::TDC_ARM_READY, 10);
    sec(5);
    cnt(8'h0, 8'h0);
    chk(8'(lk_n), 8'h1);
    p.door_open[0] = 1'b0;
    put();
    wait_st(tdc_pkg::TDC_ARMED, 6 * TK);
    sec(5);
    cnt(8'h1, 8'h2);
    rst(1'b0);
    p.door_open[0] = 1'b1;
    put();
    car.press(LK);
    wait_st(tdc_pkg::TDC_ARM_READY, 10);
    p.key_in = 1'b1;
    put();
    wait_st(tdc_pkg::TDC_NORMAL, 6);
  endtask : s_ready

  // Door opens while armed: 27 s blink, reopen, remote ends it
  task automatic s_warn();
    arm();
    clr();
    p.door_open[5] = 1'b1;
    put();
    wait_st(tdc_pkg::TDC_WARN, 6);
    wait_st(tdc_pkg::TDC_WARN_DONE, 30 * TK);
    cnt(8'he, 8'he);
    chk({6'h0, o_horn, o_hazard}, 8'h0);
    p.door_open[5] = 1'b0;
    put();
    sec(1);
    p.door_open[5] = 1'b1;
    put();
    wait_st(tdc_pkg::TDC_WARN, 6);
    car.press(PA);
    wait_st(tdc_pkg::TDC_ARMED, 1);
    chk({5'h0, o_horn, o_hazard, o_remote_alarm_request}, 8'h0);
  endtask : s_warn

  // Unlock leaves armed; 30 s idle relocks and arms
  task automatic s_relock();
    arm();
    car.press(UL);
    wait_st(tdc_pkg::TDC_RELOCK_WAIT, 6);
    clr();
    sec(28);
    wait_st(tdc_pkg::TDC_RELOCK_WAIT, 1);
    wait_st(tdc_pkg::TDC_ARMED, 3 * TK);
    sec(5);
    chk(8'(lk_n), 8'h1);
    chk(8'(horn_n != 0 && haz_n != 0), 8'h1);
  endtask : s_relock

  // Alarm request while armed: 27 s horn, stopped by remote or theft
  task automatic s_remote_alarm_request();
    arm();
    car.press(PA);
    chk({6'h0, o_horn, o_remote_alarm_request}, 8'h3);
    wait_st(tdc_pkg::TDC_ARMED, 1);
    sec(25);
    chk({6'h0, o_horn, o_remote_alarm_request}, 8'h3);
    sec(3);
    chk({6'h0, o_horn, o_remote_alarm_request}, 8'h0);
    car.press(PA);
    car.press(LI);
    chk(8'(o_remote_alarm_request), 8'h0);
    car.press(PA);
    p.door_open[2] = 1'b1;
    put();
    wait_st(tdc_pkg::TDC_WARN, 6);
    chk(8'(o_remote_alarm_request), 8'h0);
    car.press(PA);
    wait_st(tdc_pkg::TDC_ARMED, 1);
  endtask : s_remote_alarm_request

  // Ignition cancels a warning; engine start leaves armed
  task automatic s_ign();
    arm();
    p.door_open[1] = 1'b1;
    put();
    wait_st(tdc_pkg::TDC_WARN, 6);
    p.ign_on = 1'b1;
    put();
    wait_st(tdc_pkg::TDC_NORMAL, 6);
    chk({6'h0, o_horn, o_hazard}, 8'h0);
    arm();
    p.engine_run = 1'b1;
    put();
    wait_st(tdc_pkg::TDC_NORMAL, 6);
  endtask : s_ign

  // Key locking does not arm; forced unlock of the last lock warns
  task automatic s_mech();
    rst(1'b0);
    p.lock_sw = 5'h11;
    put();
    sec(2);
    wait_st(tdc_pkg::TDC_NORMAL, 1);
    car.press(LK);
    wait_st(tdc_pkg::TDC_ARMED, 10);
    sec(5);
    p.lock_sw = 5'h01;
    put();
    sec(1);
    wait_st(tdc_pkg::TDC_ARMED, 1);
    p.lock_sw = 5'h00;
    put();
    wait_st(tdc_pkg::TDC_WARN, 6);
  endtask : s_mech

  // Battery back with armed stored: warning at once
  task automatic s_restore();
    rst(1'b1);
    wait_st(tdc_pkg::TDC_WARN, 1);
  endtask : s_restore

  // Main sequence
  initial
  begin
    s_arm();
    s_ready();
    s_warn();
    s_relock();
    s_remote_alarm_request();
    s_ign();
    s_mech();
    s_restore();
    conclude();
  end
endmodule : theft_deterrent_controller_test
